// File: bench/tb_top.sv
// self-checking bench for the low-power mode controller
`timescale 1ns/1ps
`include "lpm_map.svh"
module tb_top;
  logic i_core_clk, i_nrst, i_standby_instr, i_wake_irq, i_port_output_enable_event, i_event_irq_en;
  logic i_event_flag_clear, i_independent_watchdog_enable, i_port_output_enable_unit_enable;
  logic i_timer_enable, i_vdet_enable, i_oscillator_enable;
  logic [1:0] i_mode_select;
  logic o_cpu_run, o_oscillators_run, o_pll_run, o_system_watchdog_run, o_independent_watchdog_run;
  logic o_port_output_enable_unit_run, o_eight_bit_timer_run, o_usb_host_function_module_run;
  logic o_peripheral_run, o_voltage_detector_run, o_por_run, o_core_power, o_port_hold;
  logic o_wake_interrupt, o_wake_reset, o_port_output_enable_interrupt;
  int error_cnt = 0;
  int num_checks = 0;
  low_power_mode_control low_power_mode_control_i (.*);
  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic check(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: %s got %b expected %b", $time, msg, got, exp);
    end
  endtask : check
  task automatic tick(input int n = 1);
    repeat (n) @(negedge i_core_clk);
  endtask : tick
  // a standby request is one cycle of the instruction; the mode shows one edge later
  task automatic enter(input logic [1:0] sel);
    i_mode_select = sel;
    i_standby_instr = 1'b1;
    tick();
    i_standby_instr = 1'b0;
    tick();
  endtask : enter
  // bounded wait for one of the three one-cycle pulses: 0 wake irq, 1 wake reset, 2 event irq
  task automatic wait_pulse(input int which, input string msg);
    for (int n = 0; n < 20; n++)
    begin
      tick();
      if ((which == 0 && o_wake_interrupt === 1'b1) || (which == 1 && o_wake_reset === 1'b1) ||
          (which == 2 && o_port_output_enable_interrupt === 1'b1))
        return;
    end
    check(1'b0, 1'b1, msg);
    give_verdict();
  endtask : wait_pulse
  task automatic wake(input int which);
    i_wake_irq = 1'b1;
    tick();
    i_wake_irq = 1'b0;
    wait_pulse(which, "wake pulse missing");
    check(o_wake_interrupt, which == 0, "wake irq kind");
    check(o_wake_reset, which == 1, "wake reset kind");
    tick();
    check(o_cpu_run, 1'b1, "cpu after wake");
  endtask : wake
  task automatic standby_case();
    enter(`LPM_SEL_STANDBY);
    check(o_cpu_run, 1'b0, "standby cpu");
    check(o_oscillators_run, 1'b0, "standby osc");
    check(o_pll_run, 1'b0, "standby pll");
    check(o_usb_host_function_module_run, 1'b0, "standby usb");
    check(o_eight_bit_timer_run, 1'b0, "standby timer");
    check(o_port_output_enable_unit_run, 1'b0, "standby oe unit");
    // a second instruction while asleep must not switch to deep standby
    enter(`LPM_SEL_DEEP);
    check(o_core_power, 1'b1, "instr ignored asleep");
    wake(0);
  endtask : standby_case
  task automatic deep_case();
    enter(`LPM_SEL_DEEP);
    check(o_core_power, 1'b0, "deep power");
    check(o_port_hold, 1'b1, "deep port hold");
    check(o_independent_watchdog_run, 1'b0, "deep indep wdt");
    check(o_usb_host_function_module_run, 1'b0, "deep usb");
    check(o_eight_bit_timer_run, 1'b0, "deep timer");
    check(o_por_run, 1'b1, "deep por");
    i_vdet_enable = 1'b0;
    tick(2);
    check(o_voltage_detector_run, 1'b0, "deep vdet off");
    i_vdet_enable = 1'b1;
    tick(2);
    check(o_voltage_detector_run, 1'b1, "deep vdet on");
    wake(1);
  endtask : deep_case
  task automatic clkstop_case();
    enter(`LPM_SEL_CLKSTOP);
    check(o_system_watchdog_run, 1'b0, "clkstop wdt");
    check(o_peripheral_run, 1'b0, "clkstop periph");
    check(o_port_hold, 1'b1, "clkstop port hold");
    check(o_independent_watchdog_run, 1'b1, "clkstop indep wdt on");
    check(o_eight_bit_timer_run, 1'b1, "clkstop timer on");
    check(o_port_output_enable_unit_run, 1'b1, "clkstop oe unit");
    check(o_oscillators_run, 1'b1, "clkstop osc on");
    i_independent_watchdog_enable = 1'b0;
    i_timer_enable = 1'b0;
    i_port_output_enable_unit_enable = 1'b0;
    i_oscillator_enable = 1'b0;
    tick(2);
    check(o_independent_watchdog_run, 1'b0, "clkstop indep wdt off");
    check(o_eight_bit_timer_run, 1'b0, "clkstop timer off");
    check(o_port_output_enable_unit_run, 1'b0, "clkstop oe unit off");
    check(o_oscillators_run, 1'b0, "clkstop osc off");
    check(o_pll_run, 1'b0, "clkstop pll off");
    i_independent_watchdog_enable = 1'b1;
    i_timer_enable = 1'b1;
    i_port_output_enable_unit_enable = 1'b1;
    i_oscillator_enable = 1'b1;
    i_port_output_enable_event = 1'b1;
    tick();
    i_port_output_enable_event = 1'b0;
    tick(8);
    check(o_cpu_run, 1'b0, "event woke");
    i_wake_irq = 1'b1;
    tick();
    i_wake_irq = 1'b0;
    wait_pulse(0, "clkstop wake missing");
    wait_pulse(2, "pending event irq missing");
    i_event_flag_clear = 1'b1;
    tick();
    i_event_flag_clear = 1'b0;
    tick();
    check(o_port_output_enable_interrupt, 1'b0, "event irq after clear");
    tick();
    check(o_port_output_enable_interrupt, 1'b0, "event irq after clear");
  endtask : clkstop_case
  task automatic masked_event_case();
    enter(`LPM_SEL_CLKSTOP);
    i_event_irq_en = 1'b0;
    i_port_output_enable_event = 1'b1;
    tick();
    i_port_output_enable_event = 1'b0;
    i_event_irq_en = 1'b1;
    wake(0);
    check(o_port_output_enable_interrupt, 1'b0, "masked event raised irq");
    tick();
    check(o_port_output_enable_interrupt, 1'b0, "masked event raised irq");
  endtask : masked_event_case
  // a reset in deep standby must bring the core back up in run
  task automatic reset_case();
    enter(`LPM_SEL_DEEP);
    i_nrst = 1'b0;
    tick();
    check(o_core_power, 1'b1, "reset in deep power");
    check(o_port_hold, 1'b0, "reset in deep hold");
    check(o_cpu_run, 1'b0, "reset in deep cpu");
    i_nrst = 1'b1;
    tick();
    check(o_cpu_run, 1'b1, "cpu after reset");
    check(o_port_hold, 1'b0, "hold after reset");
  endtask : reset_case
  initial
  begin
    i_nrst = 1'b0;
    i_mode_select = 2'h0;
    {i_standby_instr, i_wake_irq, i_port_output_enable_event, i_event_flag_clear} = 4'h0;
    {i_independent_watchdog_enable, i_port_output_enable_unit_enable, i_timer_enable, i_vdet_enable} = 4'hF;
    i_event_irq_en = 1'b1;
    i_oscillator_enable = 1'b1;
    tick(5);
    check(o_core_power, 1'b1, "reset power");
    check(o_port_hold, 1'b0, "reset hold");
    i_nrst = 1'b1;
    tick(2);
    check(o_cpu_run, 1'b1, "run cpu");
    check(o_peripheral_run, 1'b1, "run periph");
    enter(2'h3);
    check(o_cpu_run, 1'b1, "select 3 ignored");
    standby_case();
    deep_case();
    clkstop_case();
    masked_event_case();
    reset_case();
    give_verdict();
  end
endmodule : tb_top

// File: hdl/low_power_mode_control.sv
// low-power mode controller: clock stop, standby and deep standby
`timescale 1ns/1ps
`include "lpm_map.svh"
module low_power_mode_control
  import lpm_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic [1:0] i_mode_select,
  input wire logic i_standby_instr,
  input wire logic i_wake_irq,
  input wire logic i_port_output_enable_event,
  input wire logic i_event_irq_en,
  input wire logic i_event_flag_clear,
  input wire logic i_independent_watchdog_enable,
  input wire logic i_port_output_enable_unit_enable,
  input wire logic i_timer_enable,
  input wire logic i_vdet_enable,
  input wire logic i_oscillator_enable,
  output logic o_cpu_run,
  output logic o_oscillators_run,
  output logic o_pll_run,
  output logic o_system_watchdog_run,
  output logic o_independent_watchdog_run,
  output logic o_port_output_enable_unit_run,
  output logic o_eight_bit_timer_run,
  output logic o_usb_host_function_module_run,
  output logic o_peripheral_run,
  output logic o_voltage_detector_run,
  output logic o_por_run,
  output logic o_core_power,
  output logic o_port_hold,
  output logic o_wake_interrupt,
  output logic o_wake_reset,
  output logic o_port_output_enable_interrupt
);
  typedef struct packed {
    lpm_state_t state;
    logic [3:0] wake_cnt;
    logic wake_reset_pending;
    logic cpu_run;
    logic osc_run;
    logic pll_run;
    logic wdt_run;
    logic indep_wdt_run;
    logic poeu_run;
    logic timer_run;
    logic usb_run;
    logic per_run;
    logic vdet_run;
    logic core_power;
    logic port_hold;
    logic wake_int;
    logic wake_rst;
    logic event_int;
  } ctl_t;
  ctl_t cur;
  ctl_t next_cur;
  logic event_flag;
  logic event_in_clkstop;
  logic event_raise;
  // the flag is kept through clock stop and cleared only by i_event_flag_clear or by reset
  assign event_in_clkstop = i_port_output_enable_event && i_event_irq_en && cur.state == st_clkstop &&
    i_port_output_enable_unit_enable;
  assign event_raise = cur.state == st_run && event_flag && !cur.event_int;
  lpm_pending u_event_pending (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .i_set(event_in_clkstop),
    .i_clear(i_event_flag_clear),
    .o_flag(event_flag)
  );
  always_comb
  begin
    next_cur = cur;
    next_cur.wake_int = 1'b0;
    next_cur.wake_rst = 1'b0;
    next_cur.event_int = event_raise;
    case (cur.state)
      st_run:
      begin
        if (i_standby_instr)
        begin
          case (i_mode_select)
            `LPM_SEL_CLKSTOP: next_cur.state = st_clkstop;
            `LPM_SEL_STANDBY: next_cur.state = st_standby;
            `LPM_SEL_DEEP: next_cur.state = st_deep;
            default: next_cur.state = st_run;
          endcase
        end
      end
      st_clkstop:
      begin
        // the port output enable event alone never ends clock stop
        if (i_wake_irq)
        begin
          next_cur.state = st_wake;
          next_cur.wake_cnt = `LPM_WAKE_CYCLES;
          next_cur.wake_reset_pending = 1'b0;
        end
      end
      st_standby:
      begin
        if (i_wake_irq)
        begin
          next_cur.state = st_wake;
          next_cur.wake_cnt = `LPM_WAKE_CYCLES;
          next_cur.wake_reset_pending = 1'b0;
        end
      end
      st_deep:
      begin
        if (i_wake_irq)
        begin
          next_cur.state = st_wake;
          next_cur.wake_cnt = `LPM_WAKE_CYCLES;
          next_cur.wake_reset_pending = 1'b1;
        end
      end
      st_wake:
      begin
        // short settle so oscillators are up before the cpu resumes
        if (cur.wake_cnt == 4'h0)
        begin
          next_cur.state = st_run;
          next_cur.wake_int = !cur.wake_reset_pending;
          next_cur.wake_rst = cur.wake_reset_pending;
        end
        else
          next_cur.wake_cnt = cur.wake_cnt - 4'h1;
      end
      default: next_cur.state = st_run;
    endcase
    // module states follow the state being entered
    next_cur.vdet_run = i_vdet_enable;
    case (next_cur.state)
      st_clkstop:
      begin
        next_cur.cpu_run = 1'b0;
        next_cur.osc_run = i_oscillator_enable;
        next_cur.pll_run = i_oscillator_enable;
        next_cur.wdt_run = 1'b0;
        next_cur.indep_wdt_run = i_independent_watchdog_enable;
        next_cur.poeu_run = i_port_output_enable_unit_enable;
        next_cur.timer_run = i_timer_enable;
        next_cur.usb_run = 1'b0;
        next_cur.per_run = 1'b0;
        next_cur.core_power = 1'b1;
        next_cur.port_hold = 1'b1;
      end
      st_standby:
      begin
        next_cur.cpu_run = 1'b0;
        next_cur.osc_run = 1'b0;
        next_cur.pll_run = 1'b0;
        next_cur.wdt_run = 1'b0;
        next_cur.indep_wdt_run = i_independent_watchdog_enable;
        next_cur.poeu_run = 1'b0;
        next_cur.timer_run = 1'b0;
        next_cur.usb_run = 1'b0;
        next_cur.per_run = 1'b0;
        next_cur.core_power = 1'b1;
        next_cur.port_hold = 1'b1;
      end
      st_deep:
      begin
        next_cur.cpu_run = 1'b0;
        next_cur.osc_run = 1'b0;
        next_cur.pll_run = 1'b0;
        next_cur.wdt_run = 1'b0;
        next_cur.indep_wdt_run = 1'b0;
        next_cur.poeu_run = 1'b0;
        next_cur.timer_run = 1'b0;
        next_cur.usb_run = 1'b0;
        next_cur.per_run = 1'b0;
        next_cur.core_power = 1'b0;
        next_cur.port_hold = 1'b1;
      end
      st_wake:
      begin
        // clocks restart and core power returns, other modules keep their sleep-mode state until resume
        next_cur.osc_run = 1'b1;
        next_cur.pll_run = 1'b1;
        next_cur.core_power = 1'b1;
      end
      default:
      begin
        next_cur.cpu_run = 1'b1;
        next_cur.osc_run = 1'b1;
        next_cur.pll_run = 1'b1;
        next_cur.wdt_run = 1'b1;
        next_cur.indep_wdt_run = i_independent_watchdog_enable;
        next_cur.poeu_run = i_port_output_enable_unit_enable;
        next_cur.timer_run = i_timer_enable;
        next_cur.usb_run = 1'b1;
        next_cur.per_run = 1'b1;
        next_cur.core_power = 1'b1;
        next_cur.port_hold = 1'b0;
      end
    endcase
  end
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cur <= '0;
      cur.state <= st_run;
      cur.core_power <= 1'b1;
    end
    else
      cur <= next_cur;
  end
  assign o_cpu_run = cur.cpu_run;
  assign o_oscillators_run = cur.osc_run;
  assign o_pll_run = cur.pll_run;
  assign o_system_watchdog_run = cur.wdt_run;
  assign o_independent_watchdog_run = cur.indep_wdt_run;
  assign o_port_output_enable_unit_run = cur.poeu_run;
  assign o_eight_bit_timer_run = cur.timer_run;
  assign o_usb_host_function_module_run = cur.usb_run;
  assign o_peripheral_run = cur.per_run;
  assign o_voltage_detector_run = cur.vdet_run;
  // power-on reset circuit is never switched off
  assign o_por_run = 1'b1;
  assign o_core_power = cur.core_power;
  assign o_port_hold = cur.port_hold;
  assign o_wake_interrupt = cur.wake_int;
  assign o_wake_reset = cur.wake_rst;
  assign o_port_output_enable_interrupt = cur.event_int;

  standby_halt_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cur.state == st_standby |-> !o_oscillators_run && !o_pll_run && !o_usb_host_function_module_run)
    else $error("oscillator or usb running in standby");
  deep_unpowered_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cur.state == st_deep |-> !o_core_power && o_port_hold && !o_eight_bit_timer_run)
    else $error("core powered in deep standby");
  clkstop_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cur.state == st_clkstop |-> !o_system_watchdog_run && !o_peripheral_run && o_port_hold)
    else $error("clock stop did not halt modules");
  event_no_wake_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cur.state == st_clkstop && !i_wake_irq |=> cur.state == st_clkstop)
    else $error("clock stop left without wake");
  event_flag_kept_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    event_in_clkstop |=> event_flag)
    else $error("event flag not set");
  event_after_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    event_flag && cur.state == st_wake && !i_event_flag_clear ##1
    cur.state == st_run && !i_event_flag_clear |=> o_port_output_enable_interrupt)
    else $error("pending event not raised");
  deep_reset_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cur.state == st_deep && i_wake_irq |-> ##6 o_wake_reset)
    else $error("deep wake without reset");
  select_a: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cur.state == st_run && i_standby_instr && i_mode_select == `LPM_SEL_STANDBY |=> cur.state == st_standby)
    else $error("mode selection ignored");
endmodule : low_power_mode_control

// File: hdl/lpm_map.svh
// constants for the low-power mode controller
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_SEL_CLKSTOP 2'h0
`define LPM_SEL_STANDBY 2'h1
`define LPM_SEL_DEEP 2'h2
`define LPM_WAKE_CYCLES 4'h4
`endif

// File: hdl/lpm_pending.sv
// sticky pending flag for the port output enable event
`timescale 1ns/1ps
module lpm_pending (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_set,
  input wire logic i_clear,
  output logic o_flag
);
  typedef struct packed {
    logic flag;
  } pend_t;
  pend_t cur;
  pend_t next_cur;
  always_comb
  begin
    next_cur = cur;
    // set wins over a clear in the same cycle
    if (i_set)
      next_cur.flag = 1'b1;
    else if (i_clear)
      next_cur.flag = 1'b0;
  end
  always_ff @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      cur <= '0;
    else
      cur <= next_cur;
  end
  assign o_flag = cur.flag;
endmodule : lpm_pending

// File: hdl/lpm_pkg.sv
// types for the low-power mode controller
package lpm_pkg;
  typedef enum logic [2:0] {st_run, st_clkstop, st_standby, st_deep, st_wake} lpm_state_t;
endpackage : lpm_pkg
